// file: design/pmic_i2c_params.svh
// Constants of the two-wire sub-addressed slave port.
// Assumes a 20 MHz system clock; included by the package and the slave.
`ifndef PMIC_I2C_PARAMS_SVH
`define PMIC_I2C_PARAMS_SVH

// ==================================================
// Addresses and sub-address map
`define ADDR_BASE_WR 8'h78
`define ADDR_BASE_RD 8'h79
`define ADDR_ALT_WR 8'h7A
`define ADDR_ALT_RD 8'h7B
`define CMD_COUNT 22
`define SUB_FIRST 8'h01
`define SUB_STATUS 8'h17
`define SUB_HARD_RESET 8'h1E
`define SUB_IRQ_CLEAR 8'h1F
`define CMD_DEFAULT 8'h00

// ==================================================
// Timing
`define CLK_PERIOD_NS 50
`define BUS_MAX_KHZ 400
`define FILT_NS 100
`define FILT_CYCLES ((`FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SCL_HIGH_MIN_NS 600
`define SCL_HIGH_MIN_CYCLES (`SCL_HIGH_MIN_NS / `CLK_PERIOD_NS)

`endif

// file: design/pmic_i2c_pkg.sv
// Types shared by the two-wire slave port.
// Assumes the constants header sits beside it in design/.
`include "pmic_i2c_params.svh"

package pmic_i2c_pkg;

  // ==================================================
  // Types
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SUB,
    ST_DATA,
    ST_RD,
    ST_SKIP
  } port_state_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_s;

  typedef logic [`CMD_COUNT-1:0][7:0] cmd_bank_t;

endpackage

// file: design/pmic_i2c_subaddr_slave.sv
// Two-wire slave port with sub-addressed command registers.
// Assumes open-drain SCL and SDA with external pull-ups, a 20 MHz clock,
// and an interface supply monitor that raises supply_low below about 1V.
//
// Functional notes
// (RULE_01) Master leaves both lines high when idle.
// (RULE_02) Supply low clears port and command registers.
// (RULE_03) Port works at bus clocks up to 400kHz.
// (RULE_04) Glitch filters on sampled clock and data.
// (RULE_05) START begins address reception.
// (RULE_06) STOP ends the transfer, bus free.
// (RULE_07) Eight bits plus one acknowledge clock.
// (RULE_08) Bytes travel most significant bit first.
// (RULE_09) Acknowledge write address and every written byte.
// (RULE_10) On reads acknowledge only the read address.
// (RULE_11) Release data for master acknowledge, ignore outcome; the port ends the read on a master nack.
// (RULE_12) Address bit zero selects write or read.
// (RULE_13) Answer only to fixed variant addresses.
// (RULE_14) Twenty-two writable command registers by sub-address.
// (RULE_15) Single write is address, sub-address, data.
// (RULE_16) Any number of sub-address/data pairs follow.
// (RULE_17) Written values apply together at STOP.
// (RULE_18) Repeated START keeps pending values unapplied.
// (RULE_19) Read is pointer write, restart, read address.
// (RULE_20) Last sub-address stays stored for polling reads.
// (RULE_21) Bare read returns last written register.
// (RULE_22) Interrupt clear sub-address clears status, releases pin.
// (RULE_23) Hard reset returns command registers to defaults.
// (RULE_24) Clear and hard reset need no data byte.
// (RULE_25) Foreign address leaves data released, transfer ignored.
`timescale 1ns/1ps
`include "pmic_i2c_params.svh"

module pmic_i2c_subaddr_slave
  import pmic_i2c_pkg::*;
#(
  parameter int FILT_CYCLES = `FILT_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic supply_low,
  input wire logic variant_alt,
  input wire logic [7:0] interrupt_status_register,
  output cmd_bank_t cmd_active,
  output logic apply_pulse,
  output logic interrupt_clear_command,
  output logic hard_reset_command
);

  // ==================================================
  // Elaboration checks
  // Sync and filter delay must stay well inside the shortest clock high.
  localparam int PIPE_CYCLES = FILT_CYCLES + 3; // RULE_03
  if (FILT_CYCLES < 1 || FILT_CYCLES > 15 ||
      PIPE_CYCLES >= `SCL_HIGH_MIN_CYCLES) begin : gen_bad_filt
    $error("FILT_CYCLES out of range");
  end

  localparam cmd_bank_t DEF_BANK = {`CMD_COUNT{`CMD_DEFAULT}};
  localparam logic [3:0] FILT_LAST = 4'(FILT_CYCLES - 1);

  // ==================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic supply_low_s;
  logic variant_s;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Lines idle high, supply good and base strap until real samples arrive.
      pin_s1_r <= 4'h3;
      pin_s2_r <= 4'h3;
    end else begin
      pin_s1_r <= {variant_alt, supply_low, sda_i, scl_i};
      pin_s2_r <= pin_s1_r;
    end
  end
  assign supply_low_s = pin_s2_r[2];
  assign variant_s = pin_s2_r[3];

  // ==================================================
  // Glitch filters
  // A line changes only after FILT_CYCLES agreeing samples; spikes shorter
  // than that never reach the edge detectors.
  logic [1:0] filt_r;
  logic [1:0] filt_nxt;
  logic [1:0] prev_r;
  logic [3:0] fcnt_r [2];
  logic [3:0] fcnt_nxt [2];

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_filt
      always_comb begin
        filt_nxt[g] = filt_r[g];
        fcnt_nxt[g] = 4'h0;
        if (pin_s2_r[g] != filt_r[g]) begin // RULE_04
          if (fcnt_r[g] == FILT_LAST) begin
            filt_nxt[g] = pin_s2_r[g];
          end else begin
            fcnt_nxt[g] = fcnt_r[g] + 4'h1;
          end
        end
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          filt_r[g] <= 1'b1;
          fcnt_r[g] <= 4'h0;
        end else begin
          filt_r[g] <= filt_nxt[g];
          fcnt_r[g] <= fcnt_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 2'h3;
    end else begin
      prev_r <= filt_r;
    end
  end

  bus_s bus;
  bus_s bus_prev;
  logic rise_det;
  logic fall_det;
  logic start_det;
  logic stop_det;
  assign bus = '{scl: filt_r[0], sda: filt_r[1]};
  assign bus_prev = '{scl: prev_r[0], sda: prev_r[1]};
  assign rise_det = bus.scl && !bus_prev.scl;
  assign fall_det = !bus.scl && bus_prev.scl;
  assign start_det = bus.scl && bus_prev.scl && bus_prev.sda && !bus.sda; // RULE_05
  assign stop_det = bus.scl && bus_prev.scl && !bus_prev.sda && bus.sda; // RULE_06

  // ==================================================
  // Variant strap, caught once after reset release
  // The strap is taken on the third edge, once the synchroniser holds the pin
  // rather than its own reset value.
  logic alt_r;
  logic [1:0] strap_wait_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alt_r <= 1'b0;
      strap_wait_r <= 2'h0;
    end else if (strap_wait_r != 2'h3) begin
      strap_wait_r <= strap_wait_r + 2'h1;
      if (strap_wait_r == 2'h2) begin
        alt_r <= variant_s;
      end
    end
  end

  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  assign wr_addr = alt_r ? `ADDR_ALT_WR : `ADDR_BASE_WR; // RULE_13
  assign rd_addr = alt_r ? `ADDR_ALT_RD : `ADDR_BASE_RD; // RULE_13

  // ==================================================
  // Protocol engine
  port_state_e state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic ack_r, ack_nxt;
  logic doack_r, doack_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic oe_r, oe_nxt;
  logic apply_r, apply_nxt;
  logic clr_r, clr_nxt;
  logic hard_r, hard_nxt;
  logic wr_en;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [7:0] rd_val;
  logic [7:0] idx;
  cmd_bank_t shadow_r, shadow_nxt;
  cmd_bank_t active_r, active_nxt;

  assign rx_byte = {sh_r[6:0], bus.sda}; // RULE_08
  assign byte_done = rise_det && !ack_r && cnt_r == 4'h7 && state_r != ST_RD; // RULE_07
  assign idx = ptr_r - `SUB_FIRST;

  always_comb begin
    rd_val = 8'h00;
    if (idx < 8'(`CMD_COUNT)) begin
      rd_val = shadow_r[idx[4:0]]; // RULE_21
    end else if (ptr_r == `SUB_STATUS) begin
      rd_val = interrupt_status_register;
    end
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ack_nxt = ack_r;
    doack_nxt = doack_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    apply_nxt = 1'b0;
    clr_nxt = 1'b0;
    hard_nxt = 1'b0;
    wr_en = 1'b0;
    if (supply_low_s) begin // RULE_02
      state_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      doack_nxt = 1'b0;
      oe_nxt = 1'b0;
      ptr_nxt = 8'h00;
    end else if (start_det) begin // RULE_05
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      doack_nxt = 1'b0;
      oe_nxt = 1'b0;
    end else if (stop_det) begin // RULE_06
      state_nxt = ST_IDLE;
      cnt_nxt = 4'h0;
      ack_nxt = 1'b0;
      doack_nxt = 1'b0;
      oe_nxt = 1'b0;
      apply_nxt = 1'b1; // RULE_17
    end else if (state_r != ST_IDLE && state_r != ST_SKIP) begin
      if (rise_det) begin
        if (ack_r) begin
          // Master nack only ends our part; the port waits for STOP or START.
          if (state_r == ST_RD && bus.sda) begin // RULE_11
            state_nxt = ST_SKIP;
          end
        end else begin
          sh_nxt = rx_byte; // RULE_08
          cnt_nxt = cnt_r + 4'h1;
          if (byte_done) begin
            doack_nxt = 1'b1; // RULE_09
            case (state_r)
              ST_ADDR: begin
                if (rx_byte == wr_addr) begin // RULE_12
                  state_nxt = ST_SUB;
                end else if (rx_byte == rd_addr) begin // RULE_10
                  state_nxt = ST_RD;
                end else begin
                  doack_nxt = 1'b0; // RULE_25
                  state_nxt = ST_SKIP;
                end
              end
              ST_SUB: begin
                ptr_nxt = rx_byte; // RULE_20
                if (rx_byte == `SUB_IRQ_CLEAR) begin
                  clr_nxt = 1'b1; // RULE_22 RULE_24
                end else if (rx_byte == `SUB_HARD_RESET) begin
                  hard_nxt = 1'b1; // RULE_23 RULE_24
                end else begin
                  state_nxt = ST_DATA; // RULE_15
                end
              end
              ST_DATA: begin
                wr_en = 1'b1; // RULE_14
                state_nxt = ST_SUB; // RULE_16
              end
              default: begin
                doack_nxt = 1'b0;
              end
            endcase
          end
        end
      end else if (fall_det) begin
        if (!ack_r && cnt_r == 4'h8) begin
          ack_nxt = 1'b1;
          oe_nxt = doack_r; // RULE_09 RULE_10 RULE_11
        end else if (ack_r) begin
          ack_nxt = 1'b0;
          cnt_nxt = 4'h0;
          doack_nxt = 1'b0;
          if (state_r == ST_RD) begin // RULE_19
            tx_nxt = rd_val;
            oe_nxt = ~rd_val[7];
          end else begin
            oe_nxt = 1'b0;
          end
        end else if (state_r == ST_RD && cnt_r != 4'h0) begin
          tx_nxt = {tx_r[6:0], 1'b0}; // RULE_08
          oe_nxt = ~tx_r[6];
        end
      end
    end
  end

  // Writes land in the shadow bank; the active bank follows only at STOP,
  // so a repeated START to another device leaves pending values pending.
  generate
    for (g = 0; g < `CMD_COUNT; g++) begin : gen_bank
      always_comb begin
        shadow_nxt[g] = shadow_r[g];
        active_nxt[g] = active_r[g];
        if (supply_low_s || hard_nxt) begin // RULE_02 RULE_23
          shadow_nxt[g] = DEF_BANK[g];
          active_nxt[g] = DEF_BANK[g];
        end else if (wr_en && ptr_r == 8'(`SUB_FIRST + g)) begin // RULE_14
          shadow_nxt[g] = rx_byte;
        end else if (apply_nxt) begin // RULE_17 RULE_18
          active_nxt[g] = shadow_r[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      ack_r <= 1'b0;
      doack_r <= 1'b0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      oe_r <= 1'b0;
      apply_r <= 1'b0;
      clr_r <= 1'b0;
      hard_r <= 1'b0;
      shadow_r <= DEF_BANK;
      active_r <= DEF_BANK;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ack_r <= ack_nxt;
      doack_r <= doack_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      apply_r <= apply_nxt;
      clr_r <= clr_nxt;
      hard_r <= hard_nxt;
      shadow_r <= shadow_nxt;
      active_r <= active_nxt;
    end
  end

  // SDA is open drain: the output level is always low, only the enable moves.
  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign cmd_active = active_r;
  assign apply_pulse = apply_r;
  assign interrupt_clear_command = clr_r;
  assign hard_reset_command = hard_r;

  // ==================================================
  // Assertions
  property p_start_addr;
    @(posedge clk) disable iff (!rst_n)
      start_det && !supply_low_s |=> state_r == ST_ADDR && !sda_oe;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("START not taken"); // RULE_05

  property p_stop_idle;
    @(posedge clk) disable iff (!rst_n)
      stop_det && !supply_low_s |=> state_r == ST_IDLE && apply_pulse && !sda_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("STOP not handled"); // RULE_06

  property p_apply_copy;
    @(posedge clk) disable iff (!rst_n)
      apply_pulse && !$past(supply_low_s) && !hard_reset_command |-> cmd_active == $past(shadow_r);
  endproperty
  a_apply_copy: assert property (p_apply_copy) else $error("apply mismatch"); // RULE_17

  property p_hold_active;
    @(posedge clk) disable iff (!rst_n)
      !apply_pulse && !hard_reset_command && !$past(supply_low_s) |-> $stable(cmd_active);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("early apply"); // RULE_18

  property p_foreign;
    @(posedge clk) disable iff (!rst_n)
      byte_done && state_r == ST_ADDR && rx_byte != wr_addr && rx_byte != rd_addr
      && !supply_low_s |=> state_r == ST_SKIP;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address taken"); // RULE_25

  property p_skip_quiet;
    @(posedge clk) disable iff (!rst_n)
      state_r == ST_SKIP |-> !sda_oe;
  endproperty
  a_skip_quiet: assert property (p_skip_quiet) else $error("drive while skipped"); // RULE_25

  property p_write_ack;
    @(posedge clk) disable iff (!rst_n)
      fall_det && !ack_r && cnt_r == 4'h8 && doack_r && !start_det && !stop_det
      && !supply_low_s && state_r != ST_SKIP |=> sda_oe;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("missing acknowledge"); // RULE_09

  property p_read_release;
    @(posedge clk) disable iff (!rst_n)
      fall_det && !ack_r && cnt_r == 4'h8 && state_r == ST_RD && !doack_r |=> !sda_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("read ack not released"); // RULE_11

  property p_uvlo;
    @(posedge clk) disable iff (!rst_n)
      supply_low_s |=> cmd_active == DEF_BANK && state_r == ST_IDLE && !sda_oe;
  endproperty
  a_uvlo: assert property (p_uvlo) else $error("supply low not cleared"); // RULE_02

  property p_hard_reset;
    @(posedge clk) disable iff (!rst_n)
      hard_reset_command |-> cmd_active == DEF_BANK && shadow_r == DEF_BANK;
  endproperty
  a_hard_reset: assert property (p_hard_reset) else $error("hard reset incomplete"); // RULE_23

  property p_read_dir;
    @(posedge clk) disable iff (!rst_n)
      byte_done && state_r == ST_ADDR && rx_byte == rd_addr && !supply_low_s
      |=> state_r == ST_RD && doack_r;
  endproperty
  a_read_dir: assert property (p_read_dir) else $error("read address missed"); // RULE_12

  c_write: cover property (@(posedge clk) disable iff (!rst_n) wr_en ##[1:1000] apply_pulse);
  c_read: cover property (@(posedge clk) disable iff (!rst_n) state_r == ST_RD && ack_r);
  c_hard: cover property (@(posedge clk) disable iff (!rst_n) hard_reset_command);
  c_clear: cover property (@(posedge clk) disable iff (!rst_n) interrupt_clear_command);

endmodule

// file: sim/i2c_master_model.sv
// Two-wire bus master model that drives the slave port under test.
// Assumes pull-ups on both lines; a pull output high drives its line low.
`timescale 1ns/1ps

module i2c_master_model (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl_pull,
  output logic sda_pull
);
  // ==================================================
  // Bus phases
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  // A quarter bit of 13 clocks keeps SCL just under the top rate.
  task automatic q();
    repeat (13) @(posedge clk);
  endtask

  // Also serves as a repeated start, since SDA is released before SCL.
  task automatic start();
    sda_pull <= 1'b0;
    q();
    scl_pull <= 1'b0;
    q();
    sda_pull <= 1'b1;
    q();
    scl_pull <= 1'b1;
    q();
  endtask

  // Returns right after the edge so the caller can see the apply pulse.
  task automatic stop();
    sda_pull <= 1'b1;
    q();
    scl_pull <= 1'b0;
    q();
    sda_pull <= 1'b0;
  endtask

  // One clock of released SCL while it is low, shorter than the port's filter.
  task automatic scl_spike();
    scl_pull <= 1'b0;
    @(posedge clk);
    scl_pull <= 1'b1;
    q();
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_pull <= ~b;
    q();
    scl_pull <= 1'b0;
    q();
    r = sda_w;
    q();
    scl_pull <= 1'b1;
    q();
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~ack, r);
  endtask
endmodule

// file: sim/tb.sv
// Self-checking bench for the sub-addressed two-wire slave port.
// Assumes the master model beside it and the design package in design/.
`timescale 1ns/1ps

module tb;
  import pmic_i2c_pkg::*;
  logic clk, nrst, supply_low, variant_alt, sda_o, sda_oe;
  logic apply_pulse, interrupt_clear_command, hard_reset_command;
  logic scl_pull, sda_pull, scl_w, sda_w;
  logic [7:0] status_in;
  cmd_bank_t cmd_active;
  int fail_count = 0;
  int total_checks = 0;
  int n_clr = 0;
  int n_hard = 0;
  // Addresses of the other variant, which the base strap must ignore.
  logic [7:0] dut_addr [2] = '{8'h7A, 8'h7B};

  // ==================================================
  // Wiring
  assign scl_w = ~scl_pull;
  assign sda_w = sda_pull ? 1'b0 : (sda_oe ? sda_o : 1'b1);

  i2c_master_model m (.clk(clk), .sda_w(sda_w), .scl_pull(scl_pull), .sda_pull(sda_pull));

  pmic_i2c_subaddr_slave #(.FILT_CYCLES(2)) dut (
    .clk(clk),
    .nrst(nrst),
    .scl_i(scl_w),
    .sda_i(sda_w),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .supply_low(supply_low),
    .variant_alt(variant_alt),
    .interrupt_status_register(status_in),
    .cmd_active(cmd_active),
    .apply_pulse(apply_pulse),
    .interrupt_clear_command(interrupt_clear_command),
    .hard_reset_command(hard_reset_command)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Pulses last one clock, so they are counted rather than polled.
  always @(negedge clk) begin
    if (interrupt_clear_command === 1'b1) n_clr++;
    if (hard_reset_command === 1'b1) n_hard++;
  end

  // ==================================================
  // Helpers
  task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] d, input logic e);
    logic a;
    m.wr_byte(d, a);
    chk_bit("ack", e, a);
  endtask

  task automatic rd(input logic ack, input logic [7:0] e);
    logic [7:0] d;
    m.rd_byte(ack, d);
    chk_byte("rdata", e, d);
  endtask

  task automatic end_frame();
    m.stop();
    for (int k = 0; k < 100 && apply_pulse !== 1'b1; k++) @(negedge clk);
    chk_bit("apply", 1'b1, apply_pulse);
  endtask

  task automatic do_reset(input logic alt);
    @(posedge clk);
    nrst <= 1'b0;
    variant_alt <= alt;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (20) @(posedge clk);
  endtask

  // ==================================================
  // Scenarios
  task automatic t_write();
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h05, 1'b1);
    wr(8'hAB, 1'b1);
    wr(8'h16, 1'b1);
    wr(8'h5C, 1'b1);
    chk_byte("held", 8'h00, cmd_active[4]);
    end_frame();
    chk_byte("r05", 8'hAB, cmd_active[4]);
    chk_byte("r16", 8'h5C, cmd_active[21]);
    m.start();
    wr(8'h79, 1'b1);
    rd(1'b0, 8'h5C);
    end_frame();
  endtask

  task automatic t_read();
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h05, 1'b1);
    m.start();
    wr(8'h79, 1'b1);
    rd(1'b1, 8'hAB);
    rd(1'b0, 8'hAB);
    end_frame();
    m.start();
    wr(8'h79, 1'b1);
    rd(1'b0, 8'hAB);
    end_frame();
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h17, 1'b1);
    m.start();
    wr(8'h79, 1'b1);
    rd(1'b0, 8'hC3);
    end_frame();
  endtask

  task automatic t_restart();
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h03, 1'b1);
    wr(8'h11, 1'b1);
    m.start();
    wr(8'h50, 1'b0);
    chk_byte("kept", 8'h00, cmd_active[2]);
    end_frame();
    chk_byte("r03", 8'h11, cmd_active[2]);
    foreach (dut_addr[i]) begin
      m.start();
      wr(dut_addr[i], 1'b0);
      end_frame();
    end
  endtask

  task automatic t_cmds();
    int c0;
    int h0;
    c0 = n_clr;
    h0 = n_hard;
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h1F, 1'b1);
    wr(8'h1E, 1'b1);
    end_frame();
    chk_byte("n_clr", 8'h01, 8'(n_clr - c0));
    chk_byte("n_hard", 8'h01, 8'(n_hard - h0));
    chk_bit("dflt", 1'b1, cmd_active === '0);
  endtask

  // A one-clock spike on SCL between bytes must not shift in a bit.
  task automatic t_glitch();
    m.start();
    wr(8'h78, 1'b1);
    m.scl_spike();
    wr(8'h04, 1'b1);
    m.scl_spike();
    wr(8'h5A, 1'b1);
    end_frame();
    chk_byte("r04", 8'h5A, cmd_active[3]);
  endtask

  task automatic t_supply();
    m.start();
    wr(8'h78, 1'b1);
    wr(8'h01, 1'b1);
    wr(8'h3C, 1'b1);
    end_frame();
    chk_byte("r01", 8'h3C, cmd_active[0]);
    @(posedge clk);
    supply_low <= 1'b1;
    repeat (6) @(posedge clk);
    supply_low <= 1'b0;
    repeat (6) @(posedge clk);
    chk_bit("ulo", 1'b1, cmd_active === '0);
  endtask

  // The strap is read only after reset, so the variant needs a fresh reset.
  task automatic t_alt();
    do_reset(1'b1);
    m.start();
    wr(8'h78, 1'b0);
    end_frame();
    m.start();
    wr(8'h7A, 1'b1);
    wr(8'h02, 1'b1);
    wr(8'h66, 1'b1);
    end_frame();
    chk_byte("r02", 8'h66, cmd_active[1]);
    m.start();
    wr(8'h7B, 1'b1);
    rd(1'b0, 8'h66);
    end_frame();
  endtask

  // ==================================================
  // Sequence
  initial begin
    nrst = 1'b0;
    supply_low = 1'b0;
    variant_alt = 1'b0;
    status_in = 8'hC3;
    do_reset(1'b0);
    t_write();
    t_read();
    t_restart();
    t_cmds();
    t_glitch();
    t_supply();
    t_alt();
    test_done();
  end

  // The scenarios take about 20000 clocks; four times that means a hang.
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
